//--- core/bsc_pkg.sv
// shared constants and types for the buck four set-point configuration block
`default_nettype none
package bsc_pkg;
    localparam logic [7:0] RUN_SP_OFS     = 8'h4a;
    localparam logic [7:0] STBY_SP_OFS    = 8'h4b;
    localparam logic [7:0] SLEEP_SP_OFS   = 8'h4c;
    localparam int         SP_CODE_W      = 6;
    localparam int         RANGE_BIT      = 6;
    localparam logic [5:0] SP_RESET       = 6'h00;
    localparam logic [6:0] RESERVED_FIRST = 7'h73;
    // edges after release until the range flop stops following the sync chain
    localparam logic [1:0] RANGE_SETTLE   = 2'h3;
    localparam int         LOW_BASE_MV    = 400;
    localparam int         LOW_STEP_MV    = 25;
    localparam int         HIGH_BASE_MV   = 800;
    localparam int         HIGH_STEP_MV   = 50;
    localparam int         MV_W           = 12;
    // operating state, one-hot
    typedef enum logic [2:0] {
        BSC_RUN   = 3'h1,
        BSC_STBY  = 3'h2,
        BSC_SLEEP = 3'h4
    } bsc_state_t;
endpackage : bsc_pkg
`default_nettype wire

//--- core/bsc_code_map.sv
// combinational map of a 7-bit set-point code to millivolts
`default_nettype none
module bsc_code_map (
    input  wire logic [6:0]             code,
    output logic      [bsc_pkg::MV_W-1:0] millivolts,
    output logic                        reserved
);
    // low range 0.4 V + n*25 mV, high range 0.8 V + k*50 mV
    always_comb begin
        if (code[bsc_pkg::RANGE_BIT]) begin
            millivolts = bsc_pkg::MV_W'(bsc_pkg::HIGH_BASE_MV
                         + bsc_pkg::HIGH_STEP_MV * int'(code[5:0]));
        end else begin
            millivolts = bsc_pkg::MV_W'(bsc_pkg::LOW_BASE_MV
                         + bsc_pkg::LOW_STEP_MV * int'(code[5:0]));
        end
        reserved = (code >= bsc_pkg::RESERVED_FIRST);
    end
endmodule // bsc_code_map
`default_nettype wire

//--- core/bsc_setpoint_config.sv
// register bank and active set-point selection for buck four
`default_nettype none
module bsc_setpoint_config (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       fuse_range,
    input  wire logic       fuse_tracking,
    input  wire logic [2:0] op_state,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata_r,
    output logic      [6:0] active_code_r,
    output logic [bsc_pkg::MV_W-1:0] active_mv_r,
    output logic            active_reserved_r,
    output logic            tracking_mode_r,
    output logic            half_ref_select_r,
    output logic            forced_continuous_r
);
    logic [5:0] run_sp_r, run_sp_nxt;
    logic [5:0] stby_sp_r, stby_sp_nxt;
    logic [5:0] sleep_sp_r, sleep_sp_nxt;
    logic       range_r, range_nxt;
    logic       range_sync1_r, range_sync2_r, trk_sync1_r, trk_sync2_r;
    logic [1:0] settle_r, settle_nxt;
    logic [7:0] rdata_nxt;
    logic [6:0] code_nxt;
    logic [bsc_pkg::MV_W-1:0] mv_comb;
    logic       rsv_comb;

    // register fields and the code map are built for six set-point bits only
    if (bsc_pkg::SP_CODE_W != 6 || bsc_pkg::RANGE_BIT != bsc_pkg::SP_CODE_W) begin : g_width_check
        $error("set-point width must be six bits below the range bit");
    end

    // fuse levels are static but foreign to clk, so synchronise them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            range_sync1_r <= 1'b0;
            range_sync2_r <= 1'b0;
            trk_sync1_r   <= 1'b0;
            trk_sync2_r   <= 1'b0;
        end else begin
            range_sync1_r <= fuse_range;
            range_sync2_r <= range_sync1_r;
            trk_sync1_r   <= fuse_tracking;
            trk_sync2_r   <= trk_sync1_r;
        end
    end

    // next values of the set points; range is caught once after release
    always_comb begin
        run_sp_nxt   = run_sp_r;
        stby_sp_nxt  = stby_sp_r;
        sleep_sp_nxt = sleep_sp_r;
        range_nxt    = range_r;
        settle_nxt   = settle_r;
        // sync chain leaves reset at 0, so keep sampling until it holds the fuse level
        if (settle_r != bsc_pkg::RANGE_SETTLE) begin
            range_nxt  = range_sync2_r;
            settle_nxt = settle_r + 2'h1;
        end
        if (reg_wr) begin
            // bit 6 of write data dropped: range only from fuses
            case (reg_addr)
                bsc_pkg::RUN_SP_OFS:   run_sp_nxt   = reg_wdata[5:0];
                bsc_pkg::STBY_SP_OFS:  stby_sp_nxt  = reg_wdata[5:0];
                bsc_pkg::SLEEP_SP_OFS: sleep_sp_nxt = reg_wdata[5:0];
                default: ;
            endcase
        end
    end

    // readback; one range flop serves all three so they never diverge
    always_comb begin
        case (reg_addr)
            bsc_pkg::RUN_SP_OFS:   rdata_nxt = {1'b0, range_r, run_sp_r};
            bsc_pkg::STBY_SP_OFS:  rdata_nxt = {1'b0, range_r, stby_sp_r};
            bsc_pkg::SLEEP_SP_OFS: rdata_nxt = {1'b0, range_r, sleep_sp_r};
            default:               rdata_nxt = 8'h00;
        endcase
    end

    // pick the set point of the present operating state
    always_comb begin
        case (op_state)
            bsc_pkg::BSC_STBY:  code_nxt = {range_r, stby_sp_r};
            bsc_pkg::BSC_SLEEP: code_nxt = {range_r, sleep_sp_r};
            default:            code_nxt = {range_r, run_sp_r};
        endcase
    end

    bsc_code_map u_map (
        .code       (code_nxt),
        .millivolts (mv_comb),
        .reserved   (rsv_comb)
    );

    // register everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_sp_r            <= bsc_pkg::SP_RESET;
            stby_sp_r           <= bsc_pkg::SP_RESET;
            sleep_sp_r          <= bsc_pkg::SP_RESET;
            range_r             <= 1'b0;
            settle_r            <= 2'h0;
            reg_rdata_r         <= 8'h00;
            active_code_r       <= 7'h00;
            active_mv_r         <= bsc_pkg::MV_W'(bsc_pkg::LOW_BASE_MV); // voltage of code 0
            active_reserved_r   <= 1'b0;
            tracking_mode_r     <= 1'b0;
            half_ref_select_r   <= 1'b0;
            forced_continuous_r <= 1'b0;
        end else begin
            run_sp_r            <= run_sp_nxt;
            stby_sp_r           <= stby_sp_nxt;
            sleep_sp_r          <= sleep_sp_nxt;
            range_r             <= range_nxt;
            settle_r            <= settle_nxt;
            reg_rdata_r         <= rdata_nxt;
            active_code_r       <= code_nxt;
            active_mv_r         <= mv_comb;
            active_reserved_r   <= rsv_comb;
            tracking_mode_r     <= trk_sync2_r;
            half_ref_select_r   <= trk_sync2_r;
            forced_continuous_r <= trk_sync2_r;
        end
    end

    property p_range_locked;
        @(posedge clk) disable iff (!rst_n)
        settle_r == bsc_pkg::RANGE_SETTLE |=> $stable(range_r);
    endproperty
    a_range_locked: assert property (p_range_locked) else $error("range bit changed");

    property p_range_capture;
        @(posedge clk) disable iff (!rst_n)
        settle_r == 2'h2 |=> range_r == $past(range_sync2_r);
    endproperty
    a_range_capture: assert property (p_range_capture) else $error("range not taken");

    property p_sleep_write;
        @(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == bsc_pkg::SLEEP_SP_OFS |=> sleep_sp_r == $past(reg_wdata[5:0]);
    endproperty
    a_sleep_write: assert property (p_sleep_write) else $error("sleep set point lost");

    property p_rd_run;
        @(posedge clk) disable iff (!rst_n)
        reg_addr == bsc_pkg::RUN_SP_OFS |=>
            reg_rdata_r == {1'b0, $past(range_r), $past(run_sp_r)};
    endproperty
    a_rd_run: assert property (p_rd_run) else $error("run readback wrong");

    property p_run_write;
        @(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == bsc_pkg::RUN_SP_OFS |=> run_sp_r == $past(reg_wdata[5:0]);
    endproperty
    a_run_write: assert property (p_run_write) else $error("run set point not written");

    property p_stby_write;
        @(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == bsc_pkg::STBY_SP_OFS |=> stby_sp_r == $past(reg_wdata[5:0]);
    endproperty
    a_stby_write: assert property (p_stby_write) else $error("standby set point lost");

    property p_rd_range;
        @(posedge clk) disable iff (!rst_n)
        reg_addr == bsc_pkg::SLEEP_SP_OFS |=> reg_rdata_r[6] == $past(range_r);
    endproperty
    a_rd_range: assert property (p_rd_range) else $error("sleep range readback wrong");

    property p_top_zero;
        @(posedge clk) disable iff (!rst_n) reg_rdata_r[7] == 1'b0;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("unused bit set");

    property p_low_mv;
        @(posedge clk) disable iff (!rst_n)
        !active_code_r[6] |-> active_mv_r == bsc_pkg::MV_W'(400 + 25 * int'(active_code_r[5:0]));
    endproperty
    a_low_mv: assert property (p_low_mv) else $error("low range voltage wrong");

    property p_high_mv;
        @(posedge clk) disable iff (!rst_n)
        active_code_r[6] |-> active_mv_r == bsc_pkg::MV_W'(800 + 50 * int'(active_code_r[5:0]));
    endproperty
    a_high_mv: assert property (p_high_mv) else $error("high range voltage wrong");

    property p_rsv;
        @(posedge clk) disable iff (!rst_n)
        active_reserved_r == (active_code_r > 7'h72);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved flag wrong");

    property p_track;
        @(posedge clk) disable iff (!rst_n)
        tracking_mode_r |-> half_ref_select_r && forced_continuous_r;
    endproperty
    a_track: assert property (p_track) else $error("tracking outputs disagree");

    property p_trk_follow;
        @(posedge clk) disable iff (!rst_n)
        $rose(trk_sync2_r) |=> tracking_mode_r;
    endproperty
    a_trk_follow: assert property (p_trk_follow) else $error("tracking mode not entered");

    property p_trk_leave;
        @(posedge clk) disable iff (!rst_n)
        $fell(trk_sync2_r) |=> !tracking_mode_r && !half_ref_select_r && !forced_continuous_r;
    endproperty
    a_trk_leave: assert property (p_trk_leave) else $error("tracking mode not left");
endmodule // bsc_setpoint_config
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the buck four set-point configuration block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic                     clk;
    logic                     rst_n;
    logic                     fuse_range;
    logic                     fuse_tracking;
    logic [2:0]               op_state;
    logic                     reg_wr;
    logic [7:0]               reg_addr;
    logic [7:0]               reg_wdata;
    logic [7:0]               reg_rdata_r;
    logic [6:0]               active_code_r;
    logic [bsc_pkg::MV_W-1:0] active_mv_r;
    logic                     active_reserved_r;
    logic                     tracking_mode_r;
    logic                     half_ref_select_r;
    logic                     forced_continuous_r;
    int                       err_total;
    int                       checks;
    int                       cycles;

    bsc_setpoint_config u_bsc_setpoint_config (
        .clk(clk), .rst_n(rst_n), .fuse_range(fuse_range), .fuse_tracking(fuse_tracking),
        .op_state(op_state), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_r(reg_rdata_r), .active_code_r(active_code_r), .active_mv_r(active_mv_r),
        .active_reserved_r(active_reserved_r), .tracking_mode_r(tracking_mode_r),
        .half_ref_select_r(half_ref_select_r), .forced_continuous_r(forced_continuous_r)
    );

    // 40 mhz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard, far above the 125 or so cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // millivolts worked out from base and step of each range
    function automatic logic [11:0] exp_mv(input logic [6:0] code);
        if (code[6]) return 12'(bsc_pkg::HIGH_BASE_MV + int'(code[5:0]) * bsc_pkg::HIGH_STEP_MV);
        return 12'(bsc_pkg::LOW_BASE_MV + int'(code[5:0]) * bsc_pkg::LOW_STEP_MV);
    endfunction

    // fuse range held through all of reset so the sync chain settles
    task automatic do_reset(input logic rng);
        @(posedge clk);
        #2 rst_n = 1'b0;
        fuse_range = rng;
        repeat (16) @(posedge clk);
        #2 rst_n = 1'b1;
        repeat (4) @(posedge clk); // range settles three edges after release
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #2 reg_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #2 reg_addr = a;
        @(posedge clk);
        #1 check({4'h0, reg_rdata_r}, {4'h0, exp});
    endtask

    // mv of reserved codes is undefined, only the code and the flag are compared there
    task automatic act_chk(input logic [2:0] st, input logic [6:0] code);
        @(posedge clk);
        #2 op_state = st;
        repeat (3) @(posedge clk);
        #1 check({5'h0, active_code_r}, {5'h0, code});
        check({11'h0, active_reserved_r}, {11'h0, code >= bsc_pkg::RESERVED_FIRST});
        if (code < bsc_pkg::RESERVED_FIRST) check(active_mv_r, exp_mv(code));
    endtask

    task automatic trk_chk(input logic v);
        @(posedge clk);
        #2 fuse_tracking = v;
        repeat (4) @(posedge clk);
        #1 check({9'h0, tracking_mode_r, half_ref_select_r, forced_continuous_r}, {9'h0, {3{v}}});
    endtask

    initial begin
        rst_n = 1'b0; fuse_range = 1'b0; fuse_tracking = 1'b0; op_state = bsc_pkg::BSC_RUN;
        reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        err_total = 0; checks = 0; cycles = 0;
        do_reset(1'b0);
        for (int i = 0; i < 3; i++) rd_chk(bsc_pkg::RUN_SP_OFS + 8'(i), 8'h00);
        act_chk(bsc_pkg::BSC_RUN, 7'h00);
        wr(bsc_pkg::RUN_SP_OFS, 8'hc9);
        rd_chk(bsc_pkg::RUN_SP_OFS, 8'h09);
        wr(bsc_pkg::STBY_SP_OFS, 8'h3f);
        wr(bsc_pkg::SLEEP_SP_OFS, 8'h0a);
        act_chk(bsc_pkg::BSC_RUN, 7'h09);
        act_chk(bsc_pkg::BSC_STBY, 7'h3f);
        act_chk(bsc_pkg::BSC_SLEEP, 7'h0a);
        act_chk(3'h0, 7'h09);
        wr(8'h4d, 8'h11);
        rd_chk(8'h4d, 8'h00);
        rd_chk(bsc_pkg::RUN_SP_OFS, 8'h09);
        trk_chk(1'b1);
        trk_chk(1'b0);
        do_reset(1'b1);
        for (int i = 0; i < 3; i++) rd_chk(bsc_pkg::RUN_SP_OFS + 8'(i), 8'h40);
        act_chk(bsc_pkg::BSC_RUN, 7'h40);
        wr(bsc_pkg::RUN_SP_OFS, 8'h32);
        wr(bsc_pkg::STBY_SP_OFS, 8'h33);
        wr(bsc_pkg::SLEEP_SP_OFS, 8'h3f);
        act_chk(bsc_pkg::BSC_RUN, 7'h72);
        act_chk(bsc_pkg::BSC_STBY, 7'h73);
        act_chk(bsc_pkg::BSC_SLEEP, 7'h7f);
        wr(bsc_pkg::RUN_SP_OFS, 8'h19);
        rd_chk(bsc_pkg::RUN_SP_OFS, 8'h59);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
